// ===== rtl/ida_pkg.sv
// Shared constants and types for the ISA DMA transfer engine and bus arbiter
package ida_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SWREQ = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_XCNT = 8'h0c;
  localparam logic [7:0] OFF_CFG0 = 8'h10;
  localparam logic [7:0] OFF_CFG7 = 8'h2c;
  localparam int CTRL_ROT_LO = 0;
  localparam int CTRL_ROT_HI = 1;
  localparam int CTRL_GAT = 2;
  localparam int CFG_TIM_LSB = 0;
  localparam int CFG_TYP_LSB = 2;
  localparam int CFG_MOD_LSB = 4;
  localparam int CFG_W16_BIT = 6;
  localparam int CFG_PCI_BIT = 7;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] CFG_RST_LO = 8'h00;
  localparam logic [7:0] CFG_RST_HI = 8'h40;
  localparam logic [15:0] XCNT_RST = 16'h0000;
  localparam logic [1:0] TIM_COMPAT = 2'h0;
  localparam logic [1:0] TIM_A = 2'h1;
  localparam logic [1:0] TIM_B = 2'h2;
  localparam logic [1:0] TIM_F = 2'h3;
  localparam logic [1:0] TYP_VERIFY = 2'h0;
  localparam logic [1:0] TYP_WRITE = 2'h1;
  localparam logic [1:0] TYP_READ = 2'h2;
  localparam logic [1:0] MOD_DEMAND = 2'h0;
  localparam logic [1:0] MOD_SINGLE = 2'h1;
  localparam logic [1:0] MOD_BLOCK = 2'h2;
  localparam logic [1:0] MOD_CASCADE = 2'h3;
  localparam logic [3:0] CYC_COMPAT = 4'h8;
  localparam logic [3:0] CYC_A = 4'h6;
  localparam logic [3:0] CYC_B = 4'h5;
  localparam logic [3:0] CYC_F = 4'h3;
  localparam logic [3:0] CYC_VER_FIRST = 4'h9;
  localparam logic [3:0] CYC_VER_NEXT = 4'h8;
  localparam logic [3:0] DREQ_DELAY = 4'h8;
  localparam logic [5:0] PREEMPT_BCLK = 6'h20;
  localparam logic [7:0] CASCADE_MASK = 8'h10;
  localparam logic [1:0] OWN_DMA = 2'h0;
  localparam logic [1:0] OWN_REF = 2'h1;
  localparam logic [1:0] OWN_PCI = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAT = 5'h02,
    ST_XFER = 5'h04,
    ST_HOLD = 5'h08,
    ST_GAP = 5'h10
  } ida_state_t;
endpackage

// ===== rtl/ida_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ida_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== rtl/ida_dma_arb.sv
// ISA DMA transfer sequencer and ISA bus arbiter with APB register access
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ida_dma_arb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysclk,
  input wire logic [7:0] dreq,
  input wire logic refresh_req,
  input wire logic pci_req,
  input wire logic nmi_pending,
  input wire logic main_memory_grant_n,
  input wire logic addr_bit0,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic sbhe_n,
  output logic [7:0] dack_n,
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic pci_mem_rd,
  output logic pci_mem_wr,
  output logic count_exhausted,
  output logic refresh_gnt,
  output logic pci_gnt,
  output logic main_memory_request_n
);
  // Pin synchronisers
  logic [7:0] dreq_s;
  logic [3:0] misc_s;
  ida_sync #(.W(8)) u_sync_dreq (.clk(pclk), .rst_n(presetn), .d(dreq), .q(dreq_s));
  ida_sync #(.W(4)) u_sync_misc (.clk(pclk), .rst_n(presetn),
    .d({sysclk, refresh_req, pci_req, ~main_memory_grant_n}), .q(misc_s));
  wire sysclk_s = misc_s[3];
  wire ref_s = misc_s[2];
  wire pci_s = misc_s[1];
  wire memgnt_s = misc_s[0];
  logic sysclk_d_r;
  wire sys_edge = sysclk_s & ~sysclk_d_r;

  // Registers
  logic [2:0] ctrl_r;
  logic [7:0] swreq_r;
  logic [15:0] xcnt_r;
  logic [7:0] cfg_r [8];
  logic [7:0] pend_r;
  logic [3:0] dly_r [8];
  ida_pkg::ida_state_t st_r;
  logic [2:0] ch_r;
  logic [1:0] own_r;
  logic [1:0] rot3_r;
  logic [1:0] lo_top_r;
  logic [1:0] hi_top_r;
  logic [3:0] cyc_r;
  logic first_r;
  logic [15:0] cnt_r;
  logic [5:0] pre_r;

  // APB decode
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite;
  wire is_cfg = (paddr >= ida_pkg::OFF_CFG0) && (paddr <= ida_pkg::OFF_CFG7) && (paddr[1:0] == 2'h0);
  wire [2:0] cfg_idx = 3'((paddr - ida_pkg::OFF_CFG0) >> 2);
  wire mapped = is_cfg || paddr == ida_pkg::OFF_CTRL || paddr == ida_pkg::OFF_SWREQ ||
    paddr == ida_pkg::OFF_STAT || paddr == ida_pkg::OFF_XCNT;

  // Current channel fields
  wire [7:0] ccfg = cfg_r[ch_r];
  wire [1:0] c_tim = ccfg[ida_pkg::CFG_TIM_LSB +: 2];
  wire [1:0] c_typ = ccfg[ida_pkg::CFG_TYP_LSB +: 2];
  wire [1:0] c_mod = ccfg[ida_pkg::CFG_MOD_LSB +: 2];
  wire c_w16 = ccfg[ida_pkg::CFG_W16_BIT];
  wire c_pci = ccfg[ida_pkg::CFG_PCI_BIT];
  // ISA-side memory forces compatible cycle timing; the DREQ delay follows the programmed field
  wire [1:0] eff_tim = c_pci ? c_tim : ida_pkg::TIM_COMPAT;
  wire c_ver = (c_typ == ida_pkg::TYP_VERIFY);
  logic [3:0] per;
  always_comb begin
    case (eff_tim)
      ida_pkg::TIM_A: per = ida_pkg::CYC_A;
      ida_pkg::TIM_B: per = ida_pkg::CYC_B;
      ida_pkg::TIM_F: per = ida_pkg::CYC_F;
      default: per = ida_pkg::CYC_COMPAT;
    endcase
  end
  wire [3:0] len = c_ver ? (first_r ? ida_pkg::CYC_VER_FIRST : ida_pkg::CYC_VER_NEXT) : per;

  // Effective channel requests
  logic [7:0] hw_req;
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      hw_req[c] = dreq_s[c] & ((cfg_r[c][ida_pkg::CFG_TIM_LSB +: 2] != ida_pkg::TIM_COMPAT) ||
        (dly_r[c] == ida_pkg::DREQ_DELAY));
    end
  end
  // Software and preempt-pending requests merge with hardware ones before priority
  wire [7:0] req_eff = (hw_req | swreq_r | pend_r) & ~ida_pkg::CASCADE_MASK;

  function automatic logic [2:0] pick4(input logic [3:0] r, input logic [1:0] top);
    logic [2:0] res;
    logic [1:0] k;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      k = 2'(top + 2'(i));
      if (r[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction

  // Channel priority within and across groups
  wire [2:0] lo_pick = pick4(req_eff[3:0], lo_top_r);
  wire [2:0] hi_pick = pick4({lo_pick[2], req_eff[7], req_eff[6], req_eff[5]}, hi_top_r);
  wire dma_any = hi_pick[2];
  wire [2:0] win_ch = (hi_pick[1:0] == 2'h3) ? {1'b0, lo_pick[1:0]} : 3'(hi_pick[1:0] + 2'h1 + 2'h0) + 3'h4;

  // Three-way rotation: DMA, refresh, PCI; DMA skipped during NMI with CPU waiting
  wire dma_cand = dma_any & ~(nmi_pending & pci_s);
  wire [2:0] cands = {pci_s, ref_s, dma_cand};
  logic [1:0] win3;
  logic win3_ok;
  always_comb begin
    logic [1:0] k;
    k = 2'h0;
    win3 = 2'h0;
    win3_ok = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      k = 2'((3'(rot3_r) + 3'(i)) % 3'h3);
      if (cands[k]) begin
        win3 = k;
        win3_ok = 1'b1;
      end
    end
  end

  // Transfer progress
  wire cyc_end = (st_r == ida_pkg::ST_XFER) && sys_edge && (4'(cyc_r + 4'h1) == len);
  wire tc_hit = cyc_end && (cnt_r == 16'h0000);
  wire fast = (eff_tim != ida_pkg::TIM_COMPAT) && (c_mod != ida_pkg::MOD_CASCADE);
  wire others = ref_s | pci_s | (|(req_eff & ~(8'h01 << ch_r)));
  wire pre_exp = (pre_r == ida_pkg::PREEMPT_BCLK);
  wire stop = tc_hit || (c_mod == ida_pkg::MOD_SINGLE) || (c_mod == ida_pkg::MOD_DEMAND && !dreq_s[ch_r]) ||
    pre_exp;
  wire is_dma_win = win3_ok && (win3 == ida_pkg::OWN_DMA);
  wire win_casc = (cfg_r[win_ch][ida_pkg::CFG_MOD_LSB +: 2] == ida_pkg::MOD_CASCADE);

  ida_pkg::ida_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ida_pkg::ST_IDLE: begin
        if (win3_ok) begin
          if (is_dma_win && ctrl_r[ida_pkg::CTRL_GAT]) begin
            st_nxt = ida_pkg::ST_GAT;
          end else if (is_dma_win && !win_casc) begin
            st_nxt = ida_pkg::ST_XFER;
          end else begin
            st_nxt = ida_pkg::ST_HOLD;
          end
        end
      end
      ida_pkg::ST_GAT: begin
        if (memgnt_s) begin
          st_nxt = (c_mod == ida_pkg::MOD_CASCADE) ? ida_pkg::ST_HOLD : ida_pkg::ST_XFER;
        end
      end
      ida_pkg::ST_XFER: begin
        if (cyc_end && stop) begin
          st_nxt = ida_pkg::ST_GAP;
        end
      end
      ida_pkg::ST_HOLD: begin
        if ((own_r == ida_pkg::OWN_DMA && !dreq_s[ch_r]) || (own_r == ida_pkg::OWN_REF && !ref_s) ||
            (own_r == ida_pkg::OWN_PCI && !pci_s)) begin
          st_nxt = ida_pkg::ST_GAP;
        end
      end
      // One SYSCLK of idle bus before any new owner
      ida_pkg::ST_GAP: begin
        if (sys_edge) begin
          st_nxt = ida_pkg::ST_IDLE;
        end
      end
      default: st_nxt = ida_pkg::ST_IDLE;
    endcase
  end

  // Strobe windows: commands inside the cycle, not at its edges
  wire in_xfer = (st_r == ida_pkg::ST_XFER) && !c_ver;
  wire io_on = in_xfer && (cyc_r >= 4'h1) && (cyc_r < 4'(len - 4'h1));
  wire mem_on = io_on && ((eff_tim != ida_pkg::TIM_A) || (cyc_r >= 4'h2));
  wire is_wr = (c_typ == ida_pkg::TYP_WRITE);
  wire is_rd = (c_typ == ida_pkg::TYP_READ);
  wire dma_owned = (own_r == ida_pkg::OWN_DMA) && (st_r == ida_pkg::ST_XFER || st_r == ida_pkg::ST_HOLD);
  wire [15:0] steer = c_w16 ? data_in :
    (addr_bit0 ? {data_in[7:0], data_in[7:0]} : {8'h00, data_in[7:0]});

  // APB slave
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_cfg) begin
      rd_mux = {24'h000000, cfg_r[cfg_idx]};
    end else if (paddr == ida_pkg::OFF_CTRL) begin
      rd_mux = {29'h0, ctrl_r};
    end else if (paddr == ida_pkg::OFF_SWREQ) begin
      rd_mux = {24'h000000, swreq_r};
    end else if (paddr == ida_pkg::OFF_XCNT) begin
      rd_mux = {16'h0000, xcnt_r};
    end else if (paddr == ida_pkg::OFF_STAT) begin
      rd_mux = {6'h00, req_eff, pend_r, own_r, ch_r, st_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= rd_mux;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ida_pkg::CTRL_RST;
      xcnt_r <= ida_pkg::XCNT_RST;
      for (int c = 0; c < 8; c++) begin
        cfg_r[c] <= (c < 4) ? ida_pkg::CFG_RST_LO : ida_pkg::CFG_RST_HI;
      end
    end else if (apb_wr) begin
      if (paddr == ida_pkg::OFF_CTRL) begin
        ctrl_r <= pwdata[2:0];
      end
      if (paddr == ida_pkg::OFF_XCNT) begin
        xcnt_r <= pwdata[15:0];
      end
      if (is_cfg) begin
        cfg_r[cfg_idx] <= pwdata[7:0];
      end
    end
  end

  // Request flags: a set in the same cycle as a clear wins
  wire grant_dma = (st_r == ida_pkg::ST_IDLE) && is_dma_win;
  wire [7:0] ch_bit = 8'h01 << ch_r;
  wire [7:0] sw_clr = tc_hit ? ch_bit : 8'h00;
  wire [7:0] sw_set = (apb_wr && paddr == ida_pkg::OFF_SWREQ) ? pwdata[7:0] : 8'h00;
  wire pend_set = cyc_end && stop && pre_exp && !tc_hit && (c_mod == ida_pkg::MOD_BLOCK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swreq_r <= 8'h00;
      pend_r <= 8'h00;
    end else begin
      swreq_r <= (swreq_r & ~sw_clr) | sw_set;
      pend_r <= (pend_r & ~(grant_dma ? (8'h01 << win_ch) : 8'h00)) | (pend_set ? ch_bit : 8'h00);
    end
  end

  // Compatible DREQ delay counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_d_r <= 1'b0;
      for (int c = 0; c < 8; c++) begin
        dly_r[c] <= 4'h0;
      end
    end else begin
      sysclk_d_r <= sysclk_s;
      for (int c = 0; c < 8; c++) begin
        if (!dreq_s[c]) begin
          dly_r[c] <= 4'h0;
        end else if (sys_edge && dly_r[c] != ida_pkg::DREQ_DELAY) begin
          dly_r[c] <= 4'(dly_r[c] + 4'h1);
        end
      end
    end
  end

  // Arbitration state and priority rotation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ida_pkg::ST_IDLE;
      ch_r <= 3'h0;
      own_r <= ida_pkg::OWN_DMA;
      rot3_r <= 2'h0;
      lo_top_r <= 2'h0;
      hi_top_r <= 2'h3;
    end else begin
      st_r <= st_nxt;
      if (!ctrl_r[ida_pkg::CTRL_ROT_LO]) begin
        lo_top_r <= 2'h0;
      end
      // Fixed upper order starts at the lower group's slot, ahead of 5, 6 and 7
      if (!ctrl_r[ida_pkg::CTRL_ROT_HI]) begin
        hi_top_r <= 2'h3;
      end
      if (st_r == ida_pkg::ST_IDLE && win3_ok) begin
        own_r <= win3;
        rot3_r <= (win3 == 2'h2) ? 2'h0 : 2'(win3 + 2'h1);
        if (is_dma_win) begin
          ch_r <= win_ch;
          if (ctrl_r[ida_pkg::CTRL_ROT_LO] && !win_ch[2]) begin
            lo_top_r <= 2'(win_ch[1:0] + 2'h1);
          end
          if (ctrl_r[ida_pkg::CTRL_ROT_HI]) begin
            hi_top_r <= 2'(hi_pick[1:0] + 2'h1);
          end
        end
      end
    end
  end

  // Cycle timing, transfer count and preemption timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 4'h0;
      first_r <= 1'b1;
      cnt_r <= 16'h0000;
      pre_r <= 6'h00;
    end else if (st_r != ida_pkg::ST_XFER) begin
      cyc_r <= 4'h0;
      first_r <= 1'b1;
      cnt_r <= xcnt_r;
      pre_r <= 6'h00;
    end else if (sys_edge) begin
      if (cyc_end) begin
        cyc_r <= 4'h0;
        first_r <= 1'b0;
        cnt_r <= 16'(cnt_r - 16'h0001);
      end else begin
        cyc_r <= 4'(cyc_r + 4'h1);
      end
      // Timer starts on the first competing request and does not restart
      if (fast && (others || pre_r != 6'h00) && !pre_exp) begin
        pre_r <= 6'(pre_r + 6'h01);
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dack_n <= 8'hff;
      ior_n <= 1'b1;
      iow_n <= 1'b1;
      memr_n <= 1'b1;
      memw_n <= 1'b1;
      pci_mem_rd <= 1'b0;
      pci_mem_wr <= 1'b0;
      sbhe_n <= 1'b1;
      data_out <= 16'h0000;
      count_exhausted <= 1'b0;
      refresh_gnt <= 1'b0;
      pci_gnt <= 1'b0;
      main_memory_request_n <= 1'b1;
    end else begin
      dack_n <= dma_owned ? ~ch_bit : 8'hff;
      ior_n <= ~(io_on && is_wr);
      iow_n <= ~(io_on && is_rd);
      memw_n <= ~(mem_on && is_wr && !c_pci);
      memr_n <= ~(mem_on && is_rd && !c_pci);
      pci_mem_wr <= mem_on && is_wr && c_pci;
      pci_mem_rd <= mem_on && is_rd && c_pci;
      sbhe_n <= ~(io_on && (c_w16 || addr_bit0));
      data_out <= steer;
      count_exhausted <= tc_hit;
      refresh_gnt <= (own_r == ida_pkg::OWN_REF) && (st_r == ida_pkg::ST_HOLD);
      pci_gnt <= (own_r == ida_pkg::OWN_PCI) && (st_r == ida_pkg::ST_HOLD);
      main_memory_request_n <= ~(ctrl_r[ida_pkg::CTRL_GAT] && own_r == ida_pkg::OWN_DMA &&
        (st_r == ida_pkg::ST_GAT || st_r == ida_pkg::ST_XFER || st_r == ida_pkg::ST_HOLD));
    end
  end
endmodule

// ===== tb/ida_slave.sv
// Behavioural ISA DMA I/O slave on the far side of the engine
`timescale 1ns/1ps
module ida_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] want,
  input wire logic [7:0] dack_n,
  input wire logic ior_n,
  output logic [7:0] dreq,
  output logic [15:0] data_in
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq <= 8'h00;
      data_in <= 16'h0000;
    end else begin
      // Request held only until acknowledged, as a single-transfer slave does
      dreq <= (dreq | want) & dack_n;
      // Undriven bus outside the read strobe: keep it moving so no stale byte passes
      data_in <= !ior_n ? 16'h12a5 : ~data_in;
    end
  end
endmodule

// ===== tb/ida_dma_arb_monitor.sv
// Port-level checker for the DMA engine and bus arbiter
`timescale 1ns/1ps
module ida_dma_arb_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] dack_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic count_exhausted,
  input wire logic refresh_gnt,
  input wire logic pci_gnt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire dma_on = ~&dack_n;
  wire cmd_on = !(ior_n && iow_n && memr_n && memw_n);
  a_cascade_slot_idle: assert property (dack_n[4]) else $error("cascade slot acked");
  a_single_owner: assert property ($onehot0({~dack_n, refresh_gnt, pci_gnt})) else $error("two owners");
  a_cmd_needs_dack: assert property (cmd_on |-> dma_on) else $error("strobe without owner");
  a_write_strobes: assert property (!ior_n |-> iow_n && memr_n) else $error("bad write strobes");
  a_read_strobes: assert property (!iow_n |-> ior_n && memw_n) else $error("bad read strobes");
  a_end_releases: assert property (count_exhausted |=> !count_exhausted && !dma_on)
    else $error("service outlives count");
  a_gap_after_end: assert property ($rose(&dack_n) |=> !dma_on && !refresh_gnt && !pci_gnt)
    else $error("no idle gap");
  a_apb_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("apb wait");
  a_err_on_ready: assert property (pslverr |-> pready) else $error("stray error");
endmodule
bind ida_dma_arb ida_dma_arb_monitor ida_dma_arb_monitor_i (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .dack_n, .ior_n, .iow_n, .memr_n, .memw_n, .count_exhausted, .refresh_gnt, .pci_gnt);

// ===== tb/ida_dma_arb_bench.sv
// Self-checking bench for the DMA engine and bus arbiter
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ida_dma_arb_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sysclk = 0, sd = 0, pd = 1;
  logic refresh_req = 0, pci_req = 0, nmi_pending = 0, main_memory_grant_n = 1, addr_bit0 = 1;
  logic pready, pslverr, sbhe_n, ior_n, iow_n, memr_n, memw_n, pci_mem_rd, pci_mem_wr, er, hb;
  logic count_exhausted, refresh_gnt, pci_gnt, main_memory_request_n;
  logic [7:0] paddr = 8'h00, want = 8'h00, dreq, dack_n;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] data_in, data_out, dcap;
  logic [5:0] strb;
  int bad_count = 0, check_count = 0, n_sys, n_lat, falls, ex_cnt, first;
  always #12.5 pclk = ~pclk;
  always #100 sysclk = ~sysclk;
  ida_dma_arb ida_dma_arb_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sysclk, .dreq, .refresh_req, .pci_req, .nmi_pending, .main_memory_grant_n, .addr_bit0,
    .data_in, .data_out, .sbhe_n, .dack_n, .ior_n, .iow_n, .memr_n, .memw_n, .pci_mem_rd, .pci_mem_wr,
    .count_exhausted, .refresh_gnt, .pci_gnt, .main_memory_request_n);
  ida_slave ida_slave_i (.pclk, .presetn, .want, .dack_n, .ior_n, .dreq, .data_in);
  function automatic int idx(logic [7:0] d);
    for (int i = 7; i >= 0; i--) if (!d[i]) idx = i;
  endfunction
  // Raw sysclk edges are counted here, so lengths allow for the design's sync lag
  always @(posedge pclk) begin
    sd <= sysclk;
    pd <= &dack_n;
    strb <= strb | {~ior_n, ~iow_n, ~memr_n, ~memw_n, pci_mem_rd, pci_mem_wr};
    if (sysclk && !sd && !(&dack_n)) n_sys <= n_sys + 1;
    if (sysclk && !sd && (&dack_n) && (|dreq) && first == 8) n_lat <= n_lat + 1;
    if (pd && !(&dack_n)) falls <= falls + 1;
    if (pd && !(&dack_n) && first == 8) first <= idx(dack_n);
    if (!ior_n) dcap <= data_out;
    if (!ior_n) hb <= sbhe_n;
    if (count_exhausted === 1'b1) ex_cnt <= ex_cnt + 1;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cleared on the falling edge so the sampling process never races it
  task automatic clr();
    @(negedge pclk);
    n_sys = 0;
    n_lat = 0;
    falls = 0;
    ex_cnt = 0;
    first = 8;
    strb = 6'h00;
  endtask
  task automatic wait_ex(input int n);
    for (int i = 0; i < 40000 && ex_cnt < n; i++) @(posedge pclk);
    `CHK(ex_cnt >= n, 1'b1)
    repeat (4) @(posedge pclk);
  endtask
  task automatic run(input int ch, input logic [7:0] cfg, input logic hw);
    apb(1'b1, ida_pkg::OFF_CFG0 + 8'(4 * ch), {24'h0, cfg});
    clr();
    if (hw) begin
      @(posedge pclk);
      want <= 8'h01 << ch;
      @(posedge pclk);
      want <= 8'h00;
    end else apb(1'b1, ida_pkg::OFF_SWREQ, 32'h1 << ch);
  endtask
  task automatic t_regs();
    apb(1'b0, ida_pkg::OFF_CTRL, 32'h0);
    `CHK(rd[2:0], ida_pkg::CTRL_RST)
    apb(1'b0, ida_pkg::OFF_CFG0, 32'h0);
    `CHK(rd[7:0], ida_pkg::CFG_RST_LO)
    apb(1'b0, ida_pkg::OFF_CFG7, 32'h0);
    `CHK(rd[7:0], ida_pkg::CFG_RST_HI)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK({er, rd}, 33'h100000000)
  endtask
  task automatic t_write();
    run(1, 8'h14, 1'b1);
    wait_ex(1);
    `CHK(first, 1)
    `CHK(strb, 6'b100100)
    `CHK(n_sys inside {[7:9]}, 1'b1)
    `CHK(n_lat inside {[8:10]}, 1'b1)
    `CHK(dcap, 16'ha5a5)
    `CHK(hb, 1'b0)
  endtask
  task automatic t_read();
    run(2, 8'h9b, 1'b1);
    wait_ex(1);
    `CHK(strb, 6'b010010)
    `CHK(n_lat inside {[0:1]}, 1'b1)
    `CHK(n_sys inside {[2:4]}, 1'b1)
  endtask
  task automatic t_timing();
    logic [7:0] cfg [3] = '{8'h95, 8'h96, 8'h16};
    int len [3] = '{6, 5, 8};
    logic [5:0] st [3] = '{6'b100001, 6'b100001, 6'b100100};
    for (int k = 0; k < 3; k++) begin
      run(1, cfg[k], 1'b0);
      wait_ex(1);
      `CHK(n_sys inside {[len[k] - 1:len[k] + 1]}, 1'b1)
      `CHK(strb, st[k])
    end
  endtask
  task automatic t_verify();
    apb(1'b1, ida_pkg::OFF_XCNT, 32'h1);
    run(3, 8'h20, 1'b0);
    wait_ex(1);
    apb(1'b1, ida_pkg::OFF_XCNT, 32'h0);
    `CHK(strb, 6'h00)
    `CHK(ex_cnt, 1)
    `CHK(falls, 1)
    `CHK(n_sys inside {[16:18]}, 1'b1)
  endtask
  task automatic t_prio();
    apb(1'b1, ida_pkg::OFF_CFG0 + 8'h08, 32'h14);
    clr();
    apb(1'b1, ida_pkg::OFF_SWREQ, 32'h36);
    wait_ex(3);
    `CHK(first, 1)
    `CHK(falls, 3)
  endtask
  task automatic t_rot();
    apb(1'b1, ida_pkg::OFF_CTRL, 32'h1);
    run(1, 8'h14, 1'b0);
    wait_ex(1);
    apb(1'b1, ida_pkg::OFF_CFG0, 32'h14);
    clr();
    apb(1'b1, ida_pkg::OFF_SWREQ, 32'h05);
    wait_ex(2);
    `CHK(first, 2)
    apb(1'b1, ida_pkg::OFF_CTRL, 32'h3);
    run(0, 8'h14, 1'b0);
    wait_ex(1);
    apb(1'b1, ida_pkg::OFF_CFG0 + 8'h14, 32'h54);
    clr();
    apb(1'b1, ida_pkg::OFF_SWREQ, 32'h21);
    wait_ex(2);
    `CHK(first, 5)
    apb(1'b1, ida_pkg::OFF_CTRL, 32'h0);
  endtask
  // Refresh then PCI win first, so the rotation would next favour the DMA unit
  task automatic t_nmi();
    refresh_req <= 1'b1;
    repeat (20) @(posedge pclk);
    refresh_req <= 1'b0;
    repeat (20) @(posedge pclk);
    pci_req <= 1'b1;
    repeat (20) @(posedge pclk);
    nmi_pending <= 1'b1;
    run(1, 8'h14, 1'b0);
    @(posedge pclk);
    // One-cycle release ends the PCI hold; the request is back before the next grant
    pci_req <= 1'b0;
    @(posedge pclk);
    pci_req <= 1'b1;
    repeat (60) @(posedge pclk);
    `CHK({pci_gnt, falls == 0}, 2'b11)
    pci_req <= 1'b0;
    nmi_pending <= 1'b0;
    wait_ex(1);
    `CHK(first, 1)
  endtask
  task automatic t_gat();
    apb(1'b1, ida_pkg::OFF_CTRL, 32'h4);
    run(1, 8'h14, 1'b0);
    repeat (60) @(posedge pclk);
    `CHK({main_memory_request_n, falls == 0}, 2'b01)
    main_memory_grant_n <= 1'b0;
    wait_ex(1);
    `CHK(first, 1)
    main_memory_grant_n <= 1'b1;
    apb(1'b1, ida_pkg::OFF_CTRL, 32'h0);
  endtask
  task automatic t_preempt();
    apb(1'b1, ida_pkg::OFF_XCNT, 32'h63);
    run(1, 8'ha7, 1'b1);
    for (int i = 0; i < 400 && falls == 0; i++) @(posedge pclk);
    refresh_req <= 1'b1;
    clr();
    for (int i = 0; i < 4000 && dack_n !== 8'hff; i++) @(posedge pclk);
    `CHK(n_sys inside {[32:36]}, 1'b1)
    `CHK(ex_cnt, 0)
    repeat (20) @(posedge pclk);
    `CHK(refresh_gnt, 1'b1)
    refresh_req <= 1'b0;
    wait_ex(1);
    `CHK(falls, 1)
    apb(1'b1, ida_pkg::OFF_XCNT, 32'h0);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write();
    t_read();
    t_timing();
    t_verify();
    t_prio();
    t_rot();
    t_nmi();
    t_gat();
    t_preempt();
    summarize();
  end
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule
